// ==== core/armc_pkg.sv ====
package armc_pkg;
  localparam logic [3:0] ADR_MODE_LO = 4'h0;
  localparam logic [3:0] ADR_MODE_HI = 4'h4;
  localparam logic [3:0] ADR_STAT = 4'h8;
  localparam logic [63:0] MODE_RST = 64'h0;
  localparam int POS_RND = 14;
  localparam int POS_WIN = 12;
  localparam int POS_SIGNED = 11;
  localparam int POS_RSV = 10;
  localparam int POS_HEX_UNF = 9;
  localparam int POS_HEX_SIG = 8;
  localparam int POS_FLUSH = 7;
  localparam int POS_TRAP = 6;
  localparam int POS_AFFINE = 5;
  localparam int POS_SAT = 4;
  localparam int POS_ALT = 2;
  localparam int POS_PRI = 0;
  localparam logic [1:0] RND_BAD = 2'h3;
  localparam logic [15:0] HEX_UNF_ADJ = 16'h0080;
  localparam logic [15:0] TRAP_ADJ_S = 16'h00C0;
  localparam logic [15:0] TRAP_ADJ_D = 16'h0600;
  typedef enum logic [1:0] {
    FMT_IEEE = 2'b00, FMT_MINI_FD = 2'b01, FMT_MINI_FG = 2'b10, FMT_HEX = 2'b11
  } armc_fmt_e;
  typedef enum logic [2:0] {
    K_ADD = 3'b000, K_MUL = 3'b001, K_CMP = 3'b010, K_MAC = 3'b011,
    K_TO_ALT = 3'b100, K_FROM_ALT = 3'b101, K_SCALE = 3'b110, K_IMUL = 3'b111
  } armc_kind_e;
  typedef struct packed {
    logic [1:0] product_window_sel;
    logic mul_signed_sel;
    logic hexfmt_underflow_keep;
    logic hexfmt_signif_keep;
    logic flush_denorm_en;
    logic ieee_trap_en;
    logic inf_sign_rule_sel;
    logic clamp_overflow_en;
    armc_fmt_e second_float_fmt;
    armc_fmt_e primary_float_fmt;
  } armc_mode_s;
  typedef struct packed {
    armc_kind_e kind;
    logic dbl;
    logic sign;
    logic [15:0] exp;
    logic [51:0] sig;
    logic [51:0] den_sig;
    logic unf;
    logic ovf;
    logic zero_int;
    logic inf_inf;
    logic inf_like;
    logic inf_sign;
    logic [31:0] mul_a;
    logic [31:0] mul_b;
  } armc_op_s;
  typedef struct packed {
    armc_fmt_e fmt;
    armc_fmt_e src_fmt;
    logic sign;
    logic [15:0] exp;
    logic [51:0] sig;
    logic [31:0] int_res;
    logic invalid;
    logic trapped;
  } armc_res_s;
endpackage

// ==== core/armc_core.sv ====
`timescale 1ns/100ps
module armc_core import armc_pkg::*; (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_srst,
  // avalon-mm slave
  input wire logic [3:0] i_avm_address,
  input wire logic i_avm_read,
  input wire logic i_avm_write,
  input wire logic [31:0] i_avm_writedata,
  input wire logic [3:0] i_avm_byteenable,
  output logic [31:0] o_avm_readdata,
  output logic o_avm_waitrequest,
  // operation in
  input wire logic i_op_valid,
  input wire armc_op_s i_op,
  // result out
  output logic o_res_valid,
  output armc_res_s o_res
);
  logic [63:0] mode_q;
  logic wait_q;
  logic v_q;
  armc_op_s op_q;
  armc_mode_s md_q;
  armc_res_s res_d;

  function automatic armc_mode_s mode_dec(input logic [63:0] m);
    armc_mode_s d;
    d.product_window_sel = m[POS_WIN+:2];
    d.mul_signed_sel = m[POS_SIGNED];
    d.hexfmt_underflow_keep = m[POS_HEX_UNF];
    d.hexfmt_signif_keep = m[POS_HEX_SIG];
    d.flush_denorm_en = m[POS_FLUSH];
    d.ieee_trap_en = m[POS_TRAP];
    d.inf_sign_rule_sel = m[POS_AFFINE];
    d.clamp_overflow_en = m[POS_SAT];
    d.second_float_fmt = armc_fmt_e'(m[POS_ALT+:2]);
    d.primary_float_fmt = armc_fmt_e'(m[POS_PRI+:2]);
    return d;
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] n,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i+:8] = n[8*i+:8];
      end
    end
    return r;
  endfunction

  // exponent field mask of a format at a precision
  function automatic logic [15:0] exp_mask(input armc_fmt_e f, input logic dbl);
    case (f)
      FMT_IEEE: exp_mask = dbl ? 16'h07FF : 16'h00FF;
      FMT_MINI_FD: exp_mask = 16'h00FF;
      FMT_MINI_FG: exp_mask = dbl ? 16'h07FF : 16'h00FF;
      FMT_HEX: exp_mask = 16'h007F;
      default: exp_mask = 16'h00FF;
    endcase
  endfunction

  // one wait cycle per access; readdata is loaded together with the drop of waitrequest
  wire req = i_avm_read | i_avm_write;
  wire done = req & ~wait_q;
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~(req & wait_q);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_avm_readdata <= 32'h0;
    end else if (i_avm_read & wait_q) begin
      case (i_avm_address)
        ADR_MODE_LO: o_avm_readdata <= mode_q[31:0];
        ADR_MODE_HI: o_avm_readdata <= mode_q[63:32];
        ADR_STAT: o_avm_readdata <= {28'h0, o_res.trapped, o_res.invalid, v_q, o_res_valid};
        default: o_avm_readdata <= 32'h0;
      endcase
    end
  end
  assign o_avm_waitrequest = wait_q;

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      mode_q <= MODE_RST;
    end else if (done & i_avm_write & (i_avm_address == ADR_MODE_HI)) begin
      mode_q[63:32] <= be_merge(mode_q[63:32], i_avm_writedata, i_avm_byteenable);
    end else if (done & i_avm_write & (i_avm_address == ADR_MODE_LO)) begin
      mode_q[31:0] <= be_merge(mode_q[31:0], i_avm_writedata, i_avm_byteenable);
      mode_q[POS_RSV] <= 1'b0;
      if (i_avm_byteenable[1] & i_avm_byteenable[2] &&
          i_avm_writedata[POS_RND+1+:2] == RND_BAD) begin
        mode_q[POS_RND+:3] <= mode_q[POS_RND+:3];
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      v_q <= 1'b0;
      op_q <= '0;
      md_q <= '0;
    end else begin
      v_q <= i_op_valid;
      if (i_op_valid) begin
        op_q <= i_op;
        md_q <= mode_dec(mode_q);
      end
    end
  end

  // sign extension picks two's complement or unsigned
  wire signed [32:0] ma = {md_q.mul_signed_sel & op_q.mul_a[31], op_q.mul_a};
  wire signed [32:0] mb = {md_q.mul_signed_sel & op_q.mul_b[31], op_q.mul_b};
  wire signed [65:0] prod = ma * mb;
  // optional one-place adjust before window pick
  wire [63:0] prod_adj = md_q.product_window_sel[0] ? {prod[62:0], 1'b0} : prod[63:0];

  logic [15:0] emsk;
  logic [15:0] adj;
  logic ieee;
  logic trap;
  logic hex_op;
  always_comb begin
    res_d = '0;
    // destination follows primary except on conversion to alternate
    res_d.fmt = (op_q.kind == K_TO_ALT) ? md_q.second_float_fmt : md_q.primary_float_fmt;
    res_d.src_fmt = (op_q.kind == K_FROM_ALT) ? md_q.second_float_fmt : md_q.primary_float_fmt;
    // field codes shared by both format fields
    ieee = res_d.fmt == FMT_IEEE;
    emsk = exp_mask(res_d.fmt, op_q.dbl);
    adj = op_q.dbl ? TRAP_ADJ_D : TRAP_ADJ_S;
    trap = ieee & md_q.ieee_trap_en;
    // hex underflow keep limited to these ops
    hex_op = op_q.kind != K_IMUL;
    res_d.sign = op_q.sign;
    res_d.exp = op_q.exp & emsk;
    res_d.sig = op_q.sig;
    if (op_q.kind == K_IMUL) begin
      res_d.int_res = md_q.product_window_sel[1] ? prod_adj[63:32] : prod_adj[31:0];
    end else if (ieee & op_q.inf_inf) begin
      if (md_q.inf_sign_rule_sel & op_q.inf_like) begin
        res_d.sign = op_q.inf_sign;
        res_d.exp = emsk;
        res_d.sig = 52'h0;
      end else begin
        res_d.invalid = 1'b1;
        res_d.exp = emsk;
        res_d.sig = 52'h8000000000000;
      end
    end else if (op_q.ovf) begin
      if (trap) begin
        res_d.exp = (op_q.exp - adj) & emsk;
        res_d.trapped = 1'b1;
      end else if (md_q.clamp_overflow_en) begin
        res_d.exp = ieee ? emsk - 16'h0001 : emsk;
        res_d.sig = '1;
      end else if (ieee) begin
        res_d.exp = emsk;
        res_d.sig = 52'h0;
      end else if (res_d.fmt != FMT_HEX) begin
        // minicomputer formats flag overflow with the reserved operand pattern
        res_d.sign = 1'b1;
        res_d.exp = 16'h0;
      end
    end else if (op_q.unf) begin
      if (trap) begin
        res_d.exp = (op_q.exp + adj) & emsk;
        res_d.trapped = 1'b1;
      end else if (ieee) begin
        res_d.exp = 16'h0;
        res_d.sig = md_q.flush_denorm_en ? 52'h0 : op_q.den_sig;
      end else if ((res_d.fmt == FMT_HEX) & hex_op & md_q.hexfmt_underflow_keep) begin
        res_d.exp = (op_q.exp + HEX_UNF_ADJ) & emsk;
      end else begin
        res_d.sign = 1'b0;
        res_d.exp = 16'h0;
        res_d.sig = 52'h0;
      end
    end else if ((res_d.fmt == FMT_HEX) & op_q.zero_int &
                 ((op_q.kind == K_ADD) | (op_q.kind == K_CMP))) begin
      res_d.sig = 52'h0;
      if (!md_q.hexfmt_signif_keep) begin
        res_d.sign = 1'b0;
        res_d.exp = 16'h0;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_res_valid <= 1'b0;
      o_res <= '0;
    end else begin
      o_res_valid <= v_q;
      if (v_q) begin
        o_res <= res_d;
      end
    end
  end

  // checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  wire signed [63:0] chk_sp = $signed(op_q.mul_a) * $signed(op_q.mul_b);
  wire [63:0] chk_up = op_q.mul_a * op_q.mul_b;
  wire is_imul = v_q & (op_q.kind == K_IMUL);
  wire ieee_out = v_q & (res_d.fmt == FMT_IEEE) & (op_q.kind != K_IMUL) & ~op_q.inf_inf;
  sequence mode_write_s;
    i_avm_write & ~o_avm_waitrequest & (i_avm_address == ADR_MODE_LO);
  endsequence
  sequence op_start_s;
    i_op_valid;
  endsequence

  win_low_a: assert property (is_imul & (md_q.product_window_sel == 2'b00)
    |=> o_res.int_res == $past(chk_up[31:0])) else $error("low window wrong");
  win_adj_a: assert property (is_imul & ~md_q.mul_signed_sel & (md_q.product_window_sel == 2'b11)
    |=> o_res.int_res == $past(chk_up[62:31])) else $error("adjusted window wrong");
  mul_sign_a: assert property (is_imul & md_q.mul_signed_sel & (md_q.product_window_sel == 2'b10)
    |=> o_res.int_res == $past(chk_sp[63:32])) else $error("signed product wrong");
  flush_den_a: assert property (ieee_out & op_q.unf & ~op_q.ovf & md_q.flush_denorm_en
    & ~md_q.ieee_trap_en |=> o_res.exp == 16'h0 && o_res.sig == 52'h0
    && o_res.sign == $past(op_q.sign)) else $error("denormal flush wrong");
  trap_unf_a: assert property (ieee_out & op_q.unf & ~op_q.ovf & md_q.ieee_trap_en & op_q.dbl
    |=> o_res.trapped && o_res.exp == (($past(op_q.exp) + 16'h0600) & 16'h07FF))
    else $error("trapped underflow wrong");
  trap_ovf_a: assert property (ieee_out & op_q.ovf & md_q.ieee_trap_en & ~op_q.dbl
    |=> o_res.sig == $past(op_q.sig) && o_res.exp == (($past(op_q.exp) - 16'h00C0) & 16'h00FF))
    else $error("trapped overflow wrong");
  proj_inv_a: assert property (v_q & (res_d.fmt == FMT_IEEE) & (op_q.kind != K_IMUL)
    & op_q.inf_inf & ~md_q.inf_sign_rule_sel |=> o_res.invalid)
    else $error("projective infinity not invalid");
  hex_unf_a: assert property (v_q & (res_d.fmt == FMT_HEX) & (op_q.kind != K_IMUL) & op_q.unf
    & ~op_q.ovf & ~md_q.hexfmt_underflow_keep |=> o_res.exp == 16'h0 && o_res.sig == 52'h0)
    else $error("hex underflow not true zero");
  mode_hold_a: assert property (op_start_s ##1 (!i_op_valid)[*2]
    |-> $stable(md_q)) else $error("sampled mode changed in flight");
  rsv_bit_a: assert property (mode_write_s |=> !mode_q[POS_RSV] && mode_q[POS_RND+1+:2] != RND_BAD)
    else $error("reserved or rounding field bad");
endmodule

// ==== bench/armc_host_model.sv ====
`timescale 1ns/100ps
module armc_host_model (
  // clock
  input wire logic i_clk_sys,
  // avalon-mm master
  output logic [3:0] o_address,
  output logic o_read,
  output logic o_write,
  output logic [31:0] o_writedata,
  output logic [3:0] o_byteenable,
  input wire logic [31:0] i_readdata,
  input wire logic i_waitrequest
);
  logic [31:0] rdata;
  initial begin
    o_address = 4'h0;
    o_read = 1'b0;
    o_write = 1'b0;
    o_writedata = 32'h0;
    o_byteenable = 4'h0;
  end
  // request held until waitrequest is sampled low
  task automatic access(input logic wr, input logic [3:0] adr, input logic [31:0] d);
    @(posedge i_clk_sys);
    o_address <= adr;
    o_write <= wr;
    o_read <= !wr;
    o_writedata <= d & 32'hFFFF_FBFF;
    o_byteenable <= 4'hF;
    // only the bench watchdog ends a wait that never gets an answer
    do begin
      @(posedge i_clk_sys);
    end while (i_waitrequest !== 1'b0);
    rdata = i_readdata;
    o_read <= 1'b0;
    o_write <= 1'b0;
    // released data inverted so stale values never pass
    o_writedata <= ~d;
  endtask
endmodule

// ==== bench/arith_result_mode_control_tb_top.sv ====
`timescale 1ns/100ps
module arith_result_mode_control_tb_top import armc_pkg::*; ;
  logic clk_sys;
  logic srst;
  logic [3:0] adr;
  logic rd;
  logic wr;
  logic [31:0] wdata;
  logic [3:0] be;
  logic [31:0] rdata;
  logic waitreq;
  logic op_valid;
  armc_op_s op;
  logic res_valid;
  armc_res_s res;
  logic [63:0] mode_m;
  armc_res_s exp_q[$];
  armc_res_s msk_q[$];
  armc_res_s e_c;
  armc_res_s k_c;
  int n_mismatch;
  int checks;
  integer seed;

  armc_core dut_u (.i_clk_sys(clk_sys), .i_srst(srst), .i_avm_address(adr), .i_avm_read(rd),
    .i_avm_write(wr), .i_avm_writedata(wdata), .i_avm_byteenable(be),
    .o_avm_readdata(rdata), .o_avm_waitrequest(waitreq), .i_op_valid(op_valid), .i_op(op),
    .o_res_valid(res_valid), .o_res(res));
  armc_host_model host_u (.i_clk_sys(clk_sys), .o_address(adr), .o_read(rd), .o_write(wr),
    .o_writedata(wdata), .o_byteenable(be), .i_readdata(rdata), .i_waitrequest(waitreq));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic check(input string nm, input logic [127:0] e, input logic [127:0] s);
    checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic print_verdict();
    if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    host_u.access(1'b0, a, 32'h0);
    check("readdata", 128'(e), 128'(host_u.rdata));
  endtask

  // mirror of the mode register, updated when the write lands
  task automatic wr_mode(input logic [3:0] a, input logic [31:0] d);
    host_u.access(1'b1, a, d);
    d[POS_RSV] = 1'b0;
    if (a == ADR_MODE_LO && d[16:15] == 2'b11) d[16:14] = mode_m[16:14];
    if (a == ADR_MODE_LO) mode_m[31:0] = d;
    else mode_m[63:32] = d;
  endtask

  // one operation; expectation uses the mode seen at the taking edge
  task automatic send_op();
    logic [223:0] r;
    armc_op_s p;
    armc_res_s e;
    armc_res_s k;
    logic [63:0] pr;
    logic [15:0] adj;
    logic [15:0] emx;
    logic s;
    int sel;
    for (int i = 0; i < 7; i++) r = {r[191:0], $random(seed)};
    p = r[$bits(armc_op_s)-1:0];
    sel = $unsigned($random(seed)) % 5;
    p.unf = (sel == 1);
    p.ovf = (sel == 2);
    p.zero_int = (sel == 3);
    p.inf_inf = (sel == 4);
    if (sel == 4) p.kind = K_ADD;
    p.dbl = p.dbl | !mode_m[POS_TRAP];
    @(posedge clk_sys);
    op_valid <= 1'b1;
    op <= p;
    e = '0;
    k = '1;
    k.int_res = '0;
    e.fmt = armc_fmt_e'(p.kind == K_TO_ALT ? mode_m[POS_ALT+:2] : mode_m[POS_PRI+:2]);
    e.src_fmt = armc_fmt_e'(mode_m[POS_ALT+:2]);
    if (p.kind != K_FROM_ALT) k.src_fmt = FMT_IEEE;
    e.sign = p.sign;
    adj = p.dbl ? TRAP_ADJ_D : TRAP_ADJ_S;
    emx = p.dbl ? 16'h07FF : 16'h00FF;
    if (p.kind == K_IMUL) begin
      s = mode_m[POS_SIGNED];
      pr = {{32{s & p.mul_a[31]}}, p.mul_a} * {{32{s & p.mul_b[31]}}, p.mul_b};
      if (mode_m[POS_WIN]) pr = pr << 1;
      k = '0;
      k.int_res = '1;
      e.int_res = mode_m[POS_WIN + 1] ? pr[63:32] : pr[31:0];
    end else if (e.fmt == FMT_IEEE && p.inf_inf) begin
      e.exp = emx;
      e.invalid = !(mode_m[POS_AFFINE] && p.inf_like);
      e.sign = p.inf_sign;
      if (e.invalid) {k.sign, k.sig} = '0;
    end else if (e.fmt == FMT_IEEE && mode_m[POS_TRAP] && (p.ovf || p.unf)) begin
      e.trapped = 1'b1;
      k.sig = p.dbl ? '1 : 52'h7F_FFFF;
      e.sig = p.sig;
      e.exp = (p.ovf ? p.exp - adj : p.exp + adj) & emx;
    end else if (e.fmt == FMT_IEEE && mode_m[POS_SAT] && p.ovf) begin
      e.exp = emx - 16'h1;
      e.sig = '1;
    end else if (e.fmt == FMT_IEEE && p.unf) begin
      e.sig = mode_m[POS_FLUSH] ? 52'h0 : p.den_sig;
    end else if (e.fmt == FMT_HEX && p.unf) begin
      e.exp = mode_m[POS_HEX_UNF] ? (p.exp + HEX_UNF_ADJ) & 16'h007F : 16'h0;
      e.sign = e.sign & mode_m[POS_HEX_UNF];
      if (mode_m[POS_HEX_UNF]) k.sig = '0;
    end else if (e.fmt == FMT_HEX && p.zero_int && (p.kind == K_ADD || p.kind == K_CMP)) begin
      e.exp = mode_m[POS_HEX_SIG] ? p.exp & 16'h007F : 16'h0;
      e.sign = 1'b0;
      k.sign = !mode_m[POS_HEX_SIG];
    end else begin
      {k.sign, k.exp, k.sig} = '0;
    end
    exp_q.push_back(e);
    msk_q.push_back(k);
  endtask

  always @(posedge clk_sys) begin
    if (res_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("res_valid", 128'h0, 128'h1);
      end else begin
        e_c = exp_q.pop_front();
        k_c = msk_q.pop_front();
        check("result", 128'(e_c & k_c), 128'(res & k_c));
      end
    end
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    print_verdict();
  end

  initial begin
    srst = 1'b1;
    op_valid = 1'b0;
    op = '0;
    mode_m = MODE_RST;
    seed = 32'h4664;
    n_mismatch = 0;
    checks = 0;
    repeat (20) @(posedge clk_sys);
    srst <= 1'b0;
    rd_chk(ADR_MODE_LO, 32'h0);
    rd_chk(ADR_MODE_HI, 32'h0);
    rd_chk(4'hC, 32'h0);
    rd_chk(ADR_STAT, 32'h0);
    wr_mode(ADR_MODE_LO, 32'h0001_4000);
    wr_mode(ADR_MODE_LO, 32'h0001_8123);
    rd_chk(ADR_MODE_LO, mode_m[31:0]);
    wr_mode(ADR_MODE_HI, $random(seed));
    host_u.access(1'b1, 4'hC, 32'hFFFF_FFFF);
    rd_chk(ADR_MODE_HI, mode_m[63:32]);
    rd_chk(4'hC, 32'h0);
    for (int b = 0; b < 16; b++) begin
      wr_mode(ADR_MODE_LO, $random(seed) & 32'h0000_3BFF);
      repeat (25) send_op();
      @(posedge clk_sys);
      op_valid <= 1'b0;
    end
    repeat (4) @(posedge clk_sys);
    check("pending", 128'h0, 128'(exp_q.size()));
    print_verdict();
  end
endmodule
